// ---- logic/dual_harmonic_pkg.sv ----
// shared constants and carriers for the dual harmonic output conditioning block
// assumes one 250 MHz core clock and settings that arrive as whole per-harmonic words
package dual_harmonic_pkg;
  localparam int CLK_MHZ = 250;
  // phase in units of ten millidegrees
  localparam logic signed [15:0] PHASE_MAX = 16'sh4650; // +180.00 deg
  localparam logic signed [15:0] PHASE_MIN = -16'sh4650; // -180.00 deg
  localparam logic signed [16:0] PHASE_SPAN = 17'sh08ca0; // 360.00 deg
  localparam logic [15:0] MULT_MIN = 16'h0001;
  localparam logic [15:0] MULT_DEFAULT = 16'h0001;
  // offsets and samples in units of 0.01 % of full scale
  localparam logic signed [15:0] OFFSET_MAX = 16'sh7530; // +300.00 %
  localparam logic signed [15:0] OFFSET_MIN = -16'sh7530; // -300.00 %
  localparam logic signed [23:0] SENS_HIGH = 24'sh002710; // 100 % fs
  localparam logic signed [23:0] SENS_LOW = 24'sh000bb8; // 30 % fs
  // offset switch encodings, bit 0 gates x, bit 1 gates y
  localparam int OFF_X_BIT = 0;
  localparam int OFF_Y_BIT = 1;
  localparam logic [1:0] OFF_NONE = 2'h0;
  localparam logic [1:0] OFF_X_ONLY = 2'h1;
  localparam logic [1:0] OFF_Y_ONLY = 2'h2;
  localparam logic [1:0] OFF_BOTH = 2'h3;
  // 1-2-5 table indices, index zero is the smallest value
  localparam logic [4:0] TC_IDX_MAX = 5'h15; // 100 ks, index 0 is 10 ms
  localparam logic [4:0] TC_IDX_100MS = 5'h03; // shortest period-locked choice
  localparam logic [4:0] TC_DEFAULT = 5'h03;
  localparam logic [4:0] FS_IDX_VOLT_MAX = 5'h1a; // 1 V, index 0 is 2 nV
  localparam logic [4:0] FS_IDX_WIDE_MAX = 5'h1a; // 1 uA, index 0 is 2 fA
  localparam logic [4:0] FS_IDX_LOWN_MAX = 5'h14; // 10 nA
  localparam logic [4:0] FS_DEFAULT = 5'h18;
  localparam logic [1:0] ROLL_DEFAULT = 2'h1; // 12 dB per octave
  localparam logic [4:0] TC_SHIFT_BASE = 5'h04;
  localparam int FRAC = 16;
  localparam int ACC_W = 40;
  // highest detection frequency in dual harmonic operation, hertz
  localparam logic [47:0] DET_FREQ_MAX_HZ = 48'h000000004e20; // 20 kHz
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic signed [15:0] phase;
    logic [15:0] mult;
    logic signed [15:0] x_off;
    logic signed [15:0] y_off;
    logic [1:0] off_mode;
    logic [4:0] tc;
    logic [1:0] rolloff;
    logic [4:0] fs;
  } harm_cfg_t;

  typedef struct packed {
    logic signed [23:0] x1;
    logic signed [23:0] y1;
    logic signed [23:0] x2;
    logic signed [23:0] y2;
  } quad_sample_t;

  localparam harm_cfg_t CFG_DEFAULT = '{phase: 16'sh0000, mult: MULT_DEFAULT, x_off: 16'sh0000,
    y_off: 16'sh0000, off_mode: OFF_NONE, tc: TC_DEFAULT, rolloff: ROLL_DEFAULT, fs: FS_DEFAULT};
endpackage

// ---- logic/dual_harmonic_output_conditioning.sv ----
// output conditioning for two detection harmonics: settings, auto actions, offsets, filters
// assumes demodulator samples already in 0.01 % fs units, all inputs on core_clk
`timescale 1ns/1ps

// plain synchronous fifo with valid and ready on both sides
module sample_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // pointer and count update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset, only valid slots are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;
endmodule // sample_fifo

// Function
// - second phase setting, plus or minus 180
// - second multiplier from 1 to 65535
// - offsets within 300 percent, added when enabled
// - four-state offset switch gates x and y
// - auto-offset loads levels, enables both
// - time constant 10 ms to 100 ks
// - four roll-off choices, 6 to 24 dB
// - voltage sensitivity 2 nV to 1 V
// - current sensitivity limited by bandwidth mode
// - period-locked filtering forbids sub-100 ms constants on the first harmonic only
// - free filtering ignores harmonic period, default
// - auto actions overwrite second sensitivity, phase
// - phase, offset, sensitivity autos per harmonic
// - no combined auto-measure action exists
// - auto-default restores defaults, single reference
// - first phase setting, auto-phase may change
// - detection frequency at most 20 kHz; a multiplier above it is refused, a reference rise only sets freq_over
module dual_harmonic_output_conditioning
  import dual_harmonic_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic dual_enter,
  input wire logic [1:0] cfg_wr,
  input wire dual_harmonic_pkg::harm_cfg_t first_cfg,
  input wire dual_harmonic_pkg::harm_cfg_t second_cfg,
  input wire logic period_locked_filtering,
  input wire logic current_input,
  input wire logic low_noise,
  input wire logic [31:0] ref_freq_hz,
  input wire logic [1:0] auto_phase,
  input wire logic [1:0] auto_offset,
  input wire logic [1:0] auto_sens,
  input wire logic auto_default,
  input wire logic signed [15:0] first_meas_phase,
  input wire logic signed [15:0] second_meas_phase,
  input wire logic in_valid,
  output logic in_ready,
  input wire dual_harmonic_pkg::quad_sample_t in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output dual_harmonic_pkg::quad_sample_t out_sample,
  output dual_harmonic_pkg::harm_cfg_t first_active,
  output dual_harmonic_pkg::harm_cfg_t second_active,
  output logic dual_mode,
  output logic [1:0] freq_over
);
  import dual_harmonic_pkg::*;

  harm_cfg_t cfg_q [2];
  harm_cfg_t cfg_d [2];
  logic dual_q, dual_d;
  logic [1:0] over_q, over_d;
  logic signed [ACC_W-1:0] st_q [2][2][4];
  logic signed [ACC_W-1:0] st_d [2][2][4];
  logic signed [23:0] filt [2][2];
  logic [4:0] eff_tc [2];
  logic push_q, push_d, ready_q, ready_d;
  quad_sample_t push_data;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  quad_sample_t fifo_out;
  logic [$clog2(DEPTH):0] fifo_level;
  logic out_valid_q, out_valid_d;
  quad_sample_t out_q, out_d;
  logic take;

  // wrap a phase sum back into plus or minus 180 degrees
  function automatic logic signed [15:0] wrap_phase(input logic signed [16:0] p);
    logic signed [16:0] r;
    r = p;
    if (r > 17'(PHASE_MAX)) begin
      r = r - PHASE_SPAN;
    end else if (r < 17'(PHASE_MIN)) begin
      r = r + PHASE_SPAN;
    end
    return r[15:0];
  endfunction

  // offset level held within plus or minus 300 percent
  function automatic logic signed [15:0] clamp_off(input logic signed [24:0] v);
    if (v > 25'(OFFSET_MAX)) begin
      return OFFSET_MAX;
    end else if (v < 25'(OFFSET_MIN)) begin
      return OFFSET_MIN;
    end
    return v[15:0];
  endfunction

  // highest full-scale index allowed by the input mode
  function automatic logic [4:0] fs_limit(input logic cur, input logic lown);
    if (!cur) begin
      return FS_IDX_VOLT_MAX;
    end else if (lown) begin
      return FS_IDX_LOWN_MAX;
    end
    return FS_IDX_WIDE_MAX;
  endfunction

  // harmonic frequency check, product is wide enough for any setting
  function automatic logic freq_ok(input logic [31:0] f, input logic [15:0] m);
    logic [47:0] prod;
    prod = f * m;
    return prod <= DET_FREQ_MAX_HZ;
  endfunction

  function automatic logic signed [23:0] mag(input logic signed [23:0] v);
    return v[23] ? -v : v;
  endfunction

  // effective time constant: period-locked mode cannot go below 100 ms on harmonic one
  always_comb begin
    eff_tc[1] = cfg_q[1].tc;
    eff_tc[0] = cfg_q[0].tc;
    if (period_locked_filtering && cfg_q[0].tc < TC_IDX_100MS) begin
      eff_tc[0] = TC_IDX_100MS;
    end
  end

  // filtered outputs taken from the stage chosen by the roll-off
  always_comb begin
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 2; c++) begin
        filt[h][c] = 24'(st_q[h][c][cfg_q[h].rolloff] >>> FRAC);
      end
    end
  end

  // settings: writes, auto actions and defaults share one next-state path
  always_comb begin
    logic [4:0] lim;
    logic signed [15:0] meas;
    logic signed [23:0] m;
    lim = fs_limit(current_input, low_noise);
    meas = 16'sh0000;
    m = 24'sh000000;
    dual_d = dual_q | dual_enter;
    over_d = over_q;
    for (int h = 0; h < 2; h++) begin
      cfg_d[h] = cfg_q[h];
      meas = (h == 0) ? first_meas_phase : second_meas_phase;
      if (cfg_wr[h]) begin
        cfg_d[h].phase = wrap_phase(17'(h == 0 ? first_cfg.phase : second_cfg.phase));
        cfg_d[h].x_off = clamp_off(25'(h == 0 ? first_cfg.x_off : second_cfg.x_off));
        cfg_d[h].y_off = clamp_off(25'(h == 0 ? first_cfg.y_off : second_cfg.y_off));
        cfg_d[h].off_mode = h == 0 ? first_cfg.off_mode : second_cfg.off_mode;
        cfg_d[h].rolloff = h == 0 ? first_cfg.rolloff : second_cfg.rolloff;
        cfg_d[h].tc = h == 0 ? first_cfg.tc : second_cfg.tc;
        if (cfg_d[h].tc > TC_IDX_MAX) begin
          cfg_d[h].tc = TC_IDX_MAX;
        end
        cfg_d[h].fs = h == 0 ? first_cfg.fs : second_cfg.fs;
        if (cfg_d[h].fs > lim) begin
          cfg_d[h].fs = lim;
        end
        // zero multiplier or one above the frequency ceiling is refused
        if ((h == 0 ? first_cfg.mult : second_cfg.mult) >= MULT_MIN
            && freq_ok(ref_freq_hz, h == 0 ? first_cfg.mult : second_cfg.mult)) begin
          cfg_d[h].mult = h == 0 ? first_cfg.mult : second_cfg.mult;
        end
      end
      if (auto_phase[h]) begin
        cfg_d[h].phase = wrap_phase(17'(cfg_q[h].phase) + 17'(meas));
      end
      if (auto_offset[h]) begin
        cfg_d[h].x_off = clamp_off(25'(cfg_q[h].off_mode[OFF_X_BIT] ? cfg_q[h].x_off : 16'sh0000)
                                   - 25'(filt[h][0]));
        cfg_d[h].y_off = clamp_off(25'(cfg_q[h].off_mode[OFF_Y_BIT] ? cfg_q[h].y_off : 16'sh0000)
                                   - 25'(filt[h][1]));
        cfg_d[h].off_mode = OFF_BOTH;
      end
      // one range step per request, the control layer repeats until settled
      if (auto_sens[h]) begin
        m = mag(filt[h][0]) > mag(filt[h][1]) ? mag(filt[h][0]) : mag(filt[h][1]);
        if (m > SENS_HIGH && cfg_q[h].fs < lim) begin
          cfg_d[h].fs = cfg_q[h].fs + 5'h01;
        end else if (m < SENS_LOW && cfg_q[h].fs != 5'h00) begin
          cfg_d[h].fs = cfg_q[h].fs - 5'h01;
        end
      end
      if (cfg_d[h].fs > lim) begin
        cfg_d[h].fs = lim;
      end
      over_d[h] = !freq_ok(ref_freq_hz, cfg_q[h].mult);
    end
    // no combined auto-measure input exists; sens then phase gives the same result
    if (auto_default) begin
      cfg_d[0] = CFG_DEFAULT;
      cfg_d[1] = CFG_DEFAULT;
      dual_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_q[0] <= CFG_DEFAULT;
      cfg_q[1] <= CFG_DEFAULT;
      dual_q <= 1'b0;
      over_q <= 2'h0;
    end else begin
      cfg_q <= cfg_d;
      dual_q <= dual_d;
      over_q <= over_d;
    end
  end

  // filter cascade: each stage is y += (x - y) >> shift, shift set by the time constant
  always_comb begin
    logic signed [ACC_W-1:0] src;
    logic [5:0] sh;
    src = '0;
    sh = 6'h00;
    take = in_valid && ready_q;
    for (int h = 0; h < 2; h++) begin
      sh = 6'(eff_tc[h]) + 6'(TC_SHIFT_BASE);
      for (int c = 0; c < 2; c++) begin
        src = ACC_W'(h == 0 ? (c == 0 ? in_sample.x1 : in_sample.y1)
                            : (c == 0 ? in_sample.x2 : in_sample.y2));
        if (cfg_q[h].off_mode[c]) begin
          src = src + ACC_W'(c == 0 ? cfg_q[h].x_off : cfg_q[h].y_off);
        end
        src = src <<< FRAC;
        for (int s = 0; s < 4; s++) begin
          st_d[h][c][s] = st_q[h][c][s];
          if (take) begin
            st_d[h][c][s] = st_q[h][c][s] + ((src - st_q[h][c][s]) >>> sh);
          end
          src = st_q[h][c][s];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '{default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // push the filtered set one cycle after each accepted sample
  always_comb begin
    push_d = take;
    push_data = '{x1: filt[0][0], y1: filt[0][1], x2: filt[1][0], y2: filt[1][1]};
    // two slots spare so a sample accepted now still finds room
    ready_d = (fifo_level < ($clog2(DEPTH)+1)'(DEPTH - 2));
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      push_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      push_q <= push_d;
      ready_q <= ready_d;
    end
  end

  sample_fifo #(
    .WIDTH($bits(quad_sample_t)),
    .DEPTH(DEPTH)
  ) fifo_i (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // output register so every port leaves from a flop
  always_comb begin
    fifo_pop = !out_valid_q || out_ready;
    out_valid_d = out_valid_q && !out_ready;
    out_d = out_q;
    if (fifo_pop && fifo_out_valid) begin
      out_valid_d = 1'b1;
      out_d = fifo_out;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_valid_q <= 1'b0;
      out_q <= '0;
    end else begin
      out_valid_q <= out_valid_d;
      out_q <= out_d;
    end
  end

  assign in_ready = ready_q;
  assign out_valid = out_valid_q;
  assign out_sample = out_q;
  assign first_active = cfg_q[0];
  assign second_active = cfg_q[1];
  assign dual_mode = dual_q;
  assign freq_over = over_q;

  // checks
  sequence s_def_req;
    auto_default;
  endsequence
  sequence s_def_done;
    !dual_mode && second_active == CFG_DEFAULT;
  endsequence
  property p_phase2_range;
    @(posedge core_clk) disable iff (reset) second_active.phase <= PHASE_MAX && second_active.phase >= PHASE_MIN;
  endproperty
  a_phase2_range: assert property (p_phase2_range) else $error("second phase out of range");
  property p_mult_nonzero;
    @(posedge core_clk) disable iff (reset) second_active.mult >= MULT_MIN;
  endproperty
  a_mult_nonzero: assert property (p_mult_nonzero) else $error("multiplier zero");
  property p_off_range;
    @(posedge core_clk) disable iff (reset) first_active.x_off <= OFFSET_MAX && first_active.y_off >= OFFSET_MIN;
  endproperty
  a_off_range: assert property (p_off_range) else $error("offset beyond limit");
  property p_auto_offset;
    @(posedge core_clk) disable iff (reset) auto_offset[1] && !auto_default |=> second_active.off_mode == OFF_BOTH;
  endproperty
  a_auto_offset: assert property (p_auto_offset) else $error("auto offset left enables off");
  property p_tc_range;
    @(posedge core_clk) disable iff (reset) first_active.tc <= TC_IDX_MAX;
  endproperty
  a_tc_range: assert property (p_tc_range) else $error("time constant index too big");
  property p_fs_lown;
    @(posedge core_clk) disable iff (reset) current_input && low_noise && $stable(low_noise) && $stable(current_input)
      |=> first_active.fs <= FS_IDX_LOWN_MAX;
  endproperty
  a_fs_lown: assert property (p_fs_lown) else $error("low noise sensitivity above limit");
  property p_sync_tc;
    @(posedge core_clk) disable iff (reset) period_locked_filtering |-> eff_tc[0] >= TC_IDX_100MS;
  endproperty
  a_sync_tc: assert property (p_sync_tc) else $error("period locked constant below 100 ms");
  property p_default;
    @(posedge core_clk) disable iff (reset) s_def_req |=> s_def_done;
  endproperty
  a_default: assert property (p_default) else $error("auto default did not restore");
  property p_freq_flag;
    @(posedge core_clk) disable iff (reset) !freq_ok(ref_freq_hz, first_active.mult) && $stable(ref_freq_hz)
      && $stable(first_active.mult) |=> freq_over[0];
  endproperty
  a_freq_flag: assert property (p_freq_flag) else $error("frequency limit flag missing");
  property p_push_room;
    @(posedge core_clk) disable iff (reset) push_q |-> fifo_in_ready;
  endproperty
  a_push_room: assert property (p_push_room) else $error("buffer overrun");
endmodule // dual_harmonic_output_conditioning

// ---- bench/stream_partner.sv ----
// far-side model: demodulator feeding samples in, display stage taking them out
// assumes one core clock; the bench sets go, data and stall as levels
`timescale 1ns/1ps
module stream_partner (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic src_go,
  input wire dual_harmonic_pkg::quad_sample_t src_data,
  input wire logic stall,
  input wire logic in_ready,
  output logic in_valid,
  output dual_harmonic_pkg::quad_sample_t in_sample,
  input wire logic out_valid,
  output logic out_ready,
  input wire dual_harmonic_pkg::quad_sample_t out_sample,
  output int n_sent,
  output int n_got,
  output dual_harmonic_pkg::quad_sample_t last_out
);
  import dual_harmonic_pkg::*;
  initial begin
    in_valid = 1'b0;
    in_sample = '0;
    out_ready = 1'b0;
  end
  // source holds a sample until taken; idle data flips so stale values never look valid
  always @(posedge core_clk) begin
    if (reset) begin
      in_valid <= 1'b0;
      out_ready <= 1'b0;
      n_sent <= 0;
      n_got <= 0;
      last_out <= '0;
    end else begin
      if (in_valid && in_ready) begin
        n_sent <= n_sent + 1;
      end
      if (!(in_valid && !in_ready)) begin
        in_valid <= src_go;
        in_sample <= src_go ? src_data : ~in_sample;
      end
      out_ready <= !stall; // slow display when stalled
      if (out_valid && out_ready) begin
        n_got <= n_got + 1;
        last_out <= out_sample;
      end
    end
  end
endmodule // stream_partner

// ---- bench/tb.sv ----
// self-checking bench: settings, auto actions, offsets, filters and buffering
// assumes the design package and the partner model are compiled first
`timescale 1ns/1ps
module tb;
  import dual_harmonic_pkg::*;
  localparam int DEPTH = 8;
  localparam logic signed [15:0] PH_TAB [5] = '{16'sh4650, -16'sh4650, 16'sh4651, -16'sh4651, 16'sh7fff};
  localparam logic [15:0] ML_TAB [5] = '{16'h4e20, 16'h4e21, 16'h0000, 16'h0001, 16'hffff};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic dual_enter = 1'b0;
  logic auto_default = 1'b0;
  logic period_locked_filtering = 1'b0;
  logic current_input = 1'b0;
  logic low_noise = 1'b0;
  logic src_go = 1'b0;
  logic stall = 1'b0;
  logic [1:0] cfg_wr = 2'h0;
  logic [1:0] auto_phase = 2'h0;
  logic [1:0] auto_offset = 2'h0;
  logic [1:0] auto_sens = 2'h0;
  logic [31:0] ref_freq_hz = 32'h000003e8;
  logic signed [15:0] first_meas_phase = 16'sh0000;
  logic signed [15:0] second_meas_phase = 16'sh0000;
  harm_cfg_t first_cfg = CFG_DEFAULT;
  harm_cfg_t second_cfg = CFG_DEFAULT;
  harm_cfg_t first_active, second_active, c, d;
  harm_cfg_t exp_cfg [2];
  quad_sample_t src_data = '0;
  quad_sample_t in_sample, out_sample, last_out, held;
  logic in_valid, in_ready, out_valid, out_ready, dual_mode;
  logic [1:0] freq_over;
  logic [31:0] seed = 32'h0000c0e6;
  logic [95:0] r96;
  int n_sent, n_got, base;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  dual_harmonic_output_conditioning #(.DEPTH(DEPTH)) dual_harmonic_output_conditioning_inst (
    .core_clk(core_clk), .reset(reset), .dual_enter(dual_enter), .cfg_wr(cfg_wr),
    .first_cfg(first_cfg), .second_cfg(second_cfg), .period_locked_filtering(period_locked_filtering),
    .current_input(current_input), .low_noise(low_noise), .ref_freq_hz(ref_freq_hz),
    .auto_phase(auto_phase), .auto_offset(auto_offset), .auto_sens(auto_sens), .auto_default(auto_default),
    .first_meas_phase(first_meas_phase), .second_meas_phase(second_meas_phase), .in_valid(in_valid),
    .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample), .first_active(first_active), .second_active(second_active),
    .dual_mode(dual_mode), .freq_over(freq_over));

  stream_partner stream_partner_inst (
    .core_clk(core_clk), .reset(reset), .src_go(src_go), .src_data(src_data), .stall(stall),
    .in_ready(in_ready), .in_valid(in_valid), .in_sample(in_sample), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample), .n_sent(n_sent), .n_got(n_got), .last_out(last_out));

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_cfg(string what, harm_cfg_t e, harm_cfg_t g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_val(string what, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
    return seed;
  endfunction

  function automatic logic signed [15:0] wrap(int p);
    if (p > PHASE_MAX) begin
      p = p - PHASE_SPAN;
    end else if (p < PHASE_MIN) begin
      p = p + PHASE_SPAN;
    end
    return p[15:0];
  endfunction

  function automatic logic signed [15:0] clamp(int v);
    return v > OFFSET_MAX ? OFFSET_MAX : (v < OFFSET_MIN ? OFFSET_MIN : v[15:0]);
  endfunction

  // reference model of one settings write under the present modes
  function automatic harm_cfg_t model(harm_cfg_t old, harm_cfg_t req, int h);
    harm_cfg_t r;
    logic [4:0] lim;
    r = req;
    lim = !current_input ? FS_IDX_VOLT_MAX : (low_noise ? FS_IDX_LOWN_MAX : FS_IDX_WIDE_MAX);
    r.phase = wrap(req.phase);
    r.x_off = clamp(req.x_off);
    r.y_off = clamp(req.y_off);
    if (req.mult == 16'h0 || 48'(req.mult) * 48'(ref_freq_hz) > DET_FREQ_MAX_HZ) begin
      r.mult = old.mult;
    end
    // period-locked mode limits only the applied constant, the setting reads back as written
    if (req.tc > TC_IDX_MAX) begin
      r.tc = TC_IDX_MAX;
    end
    if (req.fs > lim) begin
      r.fs = lim;
    end
    return r;
  endfunction

  task automatic do_reset();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    exp_cfg[0] = CFG_DEFAULT;
    exp_cfg[1] = CFG_DEFAULT;
  endtask

  // one-cycle strobes; the extra edge lets the frequency flag settle
  task automatic pulse(logic [1:0] wr, logic [1:0] ap, logic [1:0] ao, logic [1:0] as, logic ad);
    @(posedge core_clk);
    cfg_wr <= wr;
    auto_phase <= ap;
    auto_offset <= ao;
    auto_sens <= as;
    auto_default <= ad;
    @(posedge core_clk);
    cfg_wr <= 2'h0;
    auto_phase <= 2'h0;
    auto_offset <= 2'h0;
    auto_sens <= 2'h0;
    auto_default <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic write_cfg(harm_cfg_t a, harm_cfg_t b);
    @(posedge core_clk);
    first_cfg <= a;
    second_cfg <= b;
    pulse(2'h3, 2'h0, 2'h0, 2'h0, 1'b0);
    exp_cfg[0] = model(exp_cfg[0], a, 0);
    exp_cfg[1] = model(exp_cfg[1], b, 1);
  endtask

  task automatic check_both();
    check_cfg("first_active", exp_cfg[0], first_active);
    check_cfg("second_active", exp_cfg[1], second_active);
  endtask

  task automatic check_freq();
    logic [1:0] e;
    e[0] = 48'(exp_cfg[0].mult) * 48'(ref_freq_hz) > DET_FREQ_MAX_HZ;
    e[1] = 48'(exp_cfg[1].mult) * 48'(ref_freq_hz) > DET_FREQ_MAX_HZ;
    check_val("freq_over", 32'(e), 32'(freq_over));
  endtask

  // stop the source, release the sink, wait until every sample came back
  task automatic drain();
    @(posedge core_clk);
    src_go <= 1'b0;
    stall <= 1'b0;
    for (int k = 0; k < 300 && (in_valid || out_valid || n_got != n_sent); k++) begin
      @(negedge core_clk);
    end
    check_val("drained", n_sent, n_got);
  endtask

  initial begin
    do_reset();
    check_both();
    @(posedge core_clk);
    dual_enter <= 1'b1;
    @(posedge core_clk);
    dual_enter <= 1'b0;
    @(negedge core_clk);
    check_val("dual_mode", 32'h1, 32'(dual_mode));
    // phase and multiplier boundaries
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      ref_freq_hz <= (i == 4) ? 32'h0 : 32'h1;
      c = CFG_DEFAULT;
      c.phase = PH_TAB[i];
      c.mult = ML_TAB[i];
      write_cfg(c, c);
      check_both();
    end
    // random settings under random modes and reference frequencies
    for (int i = 0; i < 40; i++) begin
      r96 = {rnd(), rnd(), rnd()};
      @(posedge core_clk);
      period_locked_filtering <= r96[0];
      current_input <= r96[1];
      low_noise <= r96[2];
      ref_freq_hz <= {21'h0, r96[13:3]};
      c = r96[77:0];
      c.mult = {11'h0, r96[36:32]};
      r96 = {rnd(), rnd(), rnd()};
      d = r96[77:0];
      d.mult = {11'h0, r96[36:32]};
      write_cfg(c, d);
      check_both();
      check_freq();
    end
    // auto actions on both harmonics from a known state
    @(posedge core_clk);
    period_locked_filtering <= 1'b0;
    current_input <= 1'b0;
    ref_freq_hz <= 32'h000003e8;
    first_meas_phase <= 16'sh07d0;
    second_meas_phase <= -16'sh03e8;
    c = CFG_DEFAULT;
    c.phase = 16'sh4268;
    c.x_off = 16'sh04d2;
    c.off_mode = OFF_X_ONLY;
    d = c;
    d.phase = -16'sh445c;
    write_cfg(c, d);
    pulse(2'h0, 2'h3, 2'h0, 2'h0, 1'b0);
    exp_cfg[0].phase = wrap(exp_cfg[0].phase + first_meas_phase);
    exp_cfg[1].phase = wrap(exp_cfg[1].phase + second_meas_phase);
    check_both();
    pulse(2'h0, 2'h0, 2'h3, 2'h0, 1'b0);
    exp_cfg[0].off_mode = OFF_BOTH;
    exp_cfg[1].off_mode = OFF_BOTH;
    check_both();
    pulse(2'h0, 2'h0, 2'h0, 2'h3, 1'b0);
    exp_cfg[0].fs = exp_cfg[0].fs - 5'h1;
    exp_cfg[1].fs = exp_cfg[1].fs - 5'h1;
    check_both();
    pulse(2'h3, 2'h0, 2'h0, 2'h0, 1'b1);
    exp_cfg[0] = CFG_DEFAULT;
    exp_cfg[1] = CFG_DEFAULT;
    check_both();
    check_val("dual_mode", 32'h0, 32'(dual_mode));
    // offset gating and slope depth on a zero input stream
    do_reset();
    c = CFG_DEFAULT;
    c.x_off = 16'sh1388;
    c.y_off = 16'sh1388;
    c.tc = 5'h00;
    c.rolloff = 2'h0;
    c.off_mode = OFF_X_ONLY;
    d = c;
    d.rolloff = 2'h3;
    d.off_mode = OFF_Y_ONLY;
    write_cfg(c, d);
    @(posedge core_clk);
    src_go <= 1'b1;
    for (int k = 0; k < 300 && n_sent < 30; k++) begin
      @(negedge core_clk);
    end
    drain();
    check_val("x1 offset", 32'h1, 32'(last_out.x1 > 0));
    check_val("y1 gated", 32'h0, 32'(last_out.y1));
    check_val("x2 gated", 32'h0, 32'(last_out.x2));
    check_val("slope order", 32'h1, 32'(last_out.y2 > 0 && last_out.y2 < last_out.x1));
    // fill the buffer against a stalled display, then drain
    @(posedge core_clk);
    stall <= 1'b1;
    src_go <= 1'b1;
    src_data <= {rnd(), rnd(), rnd()};
    base = n_sent;
    for (int k = 0; k < 100 && in_ready; k++) begin
      @(negedge core_clk);
    end
    check_val("refused", 32'h0, 32'(in_ready));
    held = out_sample;
    repeat (4) @(negedge core_clk);
    check_val("held", 32'h1, 32'(out_valid && out_sample === held));
    check_val("fill", 32'h1, 32'(n_sent - base >= DEPTH - 2 && n_sent - base <= DEPTH + 3));
    drain();
    // random traffic with a display that stalls at random
    for (int k = 0; k < 60; k++) begin
      r96 = {rnd(), rnd(), rnd()};
      @(posedge core_clk);
      stall <= seed[5];
      src_go <= 1'b1;
      src_data <= r96;
    end
    drain();
    tally_and_finish();
  end
endmodule // tb
